/* bench/csf_codec_model.sv */
// Behavioural external codec on the serial audio link
`timescale 1ns/1ps
module csf_codec_model (
    input wire logic run,
    input wire logic ext,
    input wire logic epol,
    input wire logic slvl,
    input wire logic dly,
    input int nbits,
    input wire logic [15:0] pattern,
    input wire logic sclk,
    input wire logic fsync,
    input wire logic dout,
    input wire logic dout_oe_n,
    output logic m_sclk,
    output logic m_fs,
    output logic din,
    output logic [15:0] cap,
    output logic hiz_seen,
    output int frames
);
    int cnt = 1000, mc = 0, idx;
    logic act_q = 1'b0;
    initial begin
        m_sclk = 1'b0;
        m_fs = 1'b0;
        din = 1'b0;
        frames = 0;
    end
    // Clock runs only while the serial clock is external, else stands still
    always #800 if (run && ext) m_sclk = ~m_sclk;
    always @(sclk or run) begin
        if (!run) begin
            cnt = 1000;
            frames = 0;
            hiz_seen = 1'b0;
            cap = 16'h0000;
            act_q = 1'b0;
            mc = 0;
        end else if (sclk == epol) begin
            if (fsync == slvl && !act_q) begin
                cnt = 0;
                frames++;
            end else if (cnt < 1000) begin
                cnt++;
            end
            act_q = fsync == slvl;
            idx = cnt - (dly ? 1 : 0);
            if (frames > 1 && cnt < 1000 && dout_oe_n) hiz_seen = 1'b1;
            else if (idx >= 0 && idx < nbits) cap[nbits - 1 - idx] = dout;
        end else begin
            // Preload the first bit, since the frame start is seen only at sampling
            idx = cnt + 1 - (dly ? 1 : 0);
            din <= (idx >= 0 && idx < nbits) ? pattern[nbits - 1 - idx] : pattern[nbits - 1];
            if (ext) m_fs <= (mc == 0) ? slvl : ~slvl;
            if (ext) mc = (mc + 1) % 16;
        end
    end
endmodule // csf_codec_model

/* bench/csf_codec_port_bench.sv */
// Self-checking bench for the codec serial port and its format register
`timescale 1ns/1ps
`include "csf_map.svh"
module csf_codec_port_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic link_clk = 1'b0, m_run = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, sclk_o, sclk_oe_n, fs_o, fs_oe_n, dout_o, dout_oe_n, din;
    logic m_sclk, m_fs, hiz_seen;
    logic [7:0] fmt = 8'h00;
    logic [15:0] pat = 16'h0000;
    logic [15:0] cap;
    int nbits = 8, frames, errors = 0, checks = 0, cyc = 0;
    logic [7:0] cfg_fmt [4] = '{8'h30, 8'h88, 8'h64, 8'h13};
    logic [2:0] cfg_code [4] = '{3'h0, 3'h1, 3'h1, 3'h0};
    logic [15:0] cfg_tx [4] = '{16'h00a5, 16'h1234, 16'h1234, 16'h005a};
    logic [15:0] cfg_pat [4] = '{16'h003c, 16'hbeef, 16'hbeef, 16'h00c3};
    wire sclk_w = sclk_oe_n ? m_sclk : sclk_o;
    wire fs_w = fs_oe_n ? m_fs : fs_o;
    always #25 pclk = ~pclk;
    // Link clock offset so its edges never line up with the bus clock
    initial #13 forever #80 link_clk = ~link_clk;
    csf_codec_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_clk(link_clk), .port_serial_clock_i(sclk_w),
        .port_serial_clock_o(sclk_o), .port_serial_clock_oe_n(sclk_oe_n),
        .port_frame_sync_i(fs_w), .port_frame_sync_o(fs_o), .port_frame_sync_oe_n(fs_oe_n),
        .port_serial_data_out_o(dout_o), .port_serial_data_out_oe_n(dout_oe_n),
        .port_serial_data_in_i(din));
    csf_codec_model partner (.run(m_run), .ext(fmt[1]), .epol(fmt[5]), .slvl(fmt[4]),
        .dly(fmt[7]), .nbits(nbits), .pattern(pat), .sclk(sclk_w), .fsync(fs_w),
        .dout(dout_o), .dout_oe_n(dout_oe_n), .m_sclk(m_sclk), .m_fs(m_fs), .din(din),
        .cap(cap), .hiz_seen(hiz_seen), .frames(frames));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 32'h00000000, rd, err);
        check(what, exp, rd);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        logic [31:0] rd, ctrl;
        logic err;
        logic [15:0] exp;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("format reset", `CSF_IDX_FMT, 32'h00000030);
        rdchk("status reset", `CSF_IDX_STAT, 32'h00000001);
        apb(1'b0, 16'h0100, 32'h00000000, rd, err);
        check("unmapped error", 32'h00000001, {31'h0, err});
        // Two slots per frame, data in slot zero; a table of formats
        for (int i = 0; i < 4; i++) begin
            ctrl = 32'h00000040 | (32'(cfg_code[i]) << 3);
            apb(1'b1, `CSF_IDX_CTRL, ctrl, rd, err);
            apb(1'b1, `CSF_IDX_FMT, {24'h0, cfg_fmt[i]}, rd, err);
            apb(1'b1, `CSF_IDX_TXD, {16'h0, cfg_tx[i]}, rd, err);
            fmt <= cfg_fmt[i];
            pat <= cfg_pat[i];
            nbits <= (cfg_code[i] == 3'h0) ? 8 : 16;
            m_run <= 1'b1;
            apb(1'b1, `CSF_IDX_CTRL, ctrl | 32'h00000001, rd, err);
            for (int n = 0; n < 6000 && frames < 4; n++) @(posedge pclk);
            check("frames", 32'd4, 32'(frames));
            exp = cfg_fmt[i][2] ? {cfg_tx[i][7:0], cfg_tx[i][15:8]} : cfg_tx[i];
            check("wire word", {16'h0, exp}, {16'h0, cap});
            exp = cfg_fmt[i][2] ? {cfg_pat[i][7:0], cfg_pat[i][15:8]} : cfg_pat[i];
            rdchk("rx word", `CSF_IDX_RXD, {16'h0, exp});
            check("hiz seen", {31'h0, cfg_fmt[i][6]}, {31'h0, hiz_seen});
            check("clock dir", {31'h0, cfg_fmt[i][1]}, {31'h0, sclk_oe_n});
            check("sync dir", {31'h0, cfg_fmt[i][0]}, {31'h0, fs_oe_n});
            apb(1'b1, `CSF_IDX_FMT, 32'h000000ff, rd, err);
            rdchk("format locked", `CSF_IDX_FMT, {24'h0, cfg_fmt[i]});
            apb(1'b1, `CSF_IDX_CTRL, 32'h00000000, rd, err);
            m_run <= 1'b0;
        end
        tally_and_finish();
    end
endmodule // csf_codec_port_bench
bind csf_codec_port csf_codec_port_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
    .port_serial_clock_o(port_serial_clock_o), .port_serial_clock_oe_n(port_serial_clock_oe_n),
    .port_frame_sync_o(port_frame_sync_o), .port_frame_sync_oe_n(port_frame_sync_oe_n),
    .port_serial_data_out_o(port_serial_data_out_o),
    .port_serial_data_out_oe_n(port_serial_data_out_oe_n));

/* bench/csf_codec_port_monitor.sv */
// Concurrent checks on the ports of the codec serial port
`timescale 1ns/1ps
`include "csf_map.svh"
module csf_codec_port_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic link_clk,
    input wire logic port_serial_clock_o,
    input wire logic port_serial_clock_oe_n,
    input wire logic port_frame_sync_o,
    input wire logic port_frame_sync_oe_n,
    input wire logic port_serial_data_out_o,
    input wire logic port_serial_data_out_oe_n
);
    localparam logic [17:0] FMT_A = {`CSF_IDX_FMT, 2'b00};
    localparam logic [17:0] CTRL_A = {`CSF_IDX_CTRL, 2'b00};
    logic [7:0] fmt_q;
    logic en_q;
    logic [5:0] en_cnt_q;
    logic wr_acc, en_ok, int_clk, sync_act;
    assign wr_acc = psel && penable && pready && pwrite;
    assign en_ok = en_cnt_q == 6'h3f;
    assign int_clk = en_ok && !fmt_q[1] && !fmt_q[0];
    assign sync_act = port_frame_sync_o == fmt_q[4];
    // Shadow of the format byte, frozen while the port runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fmt_q <= `CSF_FMT_RST;
        else if (wr_acc && paddr == FMT_A && !en_q) fmt_q <= pwdata[7:0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) en_q <= 1'b0;
        else if (wr_acc && paddr == CTRL_A) en_q <= pwdata[0];
    end
    // Margin for the enable to cross into the link domain and start framing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) en_cnt_q <= 6'h00;
        else if (!en_q) en_cnt_q <= 6'h00;
        else if (!en_ok) en_cnt_q <= en_cnt_q + 6'h01;
    end
    a_err_access: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> psel && penable) else $error("pslverr outside access phase");
    a_fmt_locked: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == FMT_A |-> prdata[7:0] == fmt_q)
        else $error("format readback differs from accepted writes");
    a_clk_dir: assert property (@(posedge pclk) disable iff (!presetn)
        en_ok |-> port_serial_clock_oe_n == fmt_q[1]) else $error("serial clock direction");
    a_sync_dir: assert property (@(posedge pclk) disable iff (!presetn)
        en_ok |-> port_frame_sync_oe_n == fmt_q[0]) else $error("frame sync direction");
    a_pad_drive: assert property (@(posedge pclk) disable iff (!presetn)
        int_clk && !fmt_q[6] |-> !port_serial_data_out_oe_n) else $error("pad not driven");
    a_sync_short: assert property (@(posedge link_clk) disable iff (!presetn || !int_clk)
        $rose(sync_act) && !fmt_q[3] |-> sync_act[*4] ##1 !sync_act)
        else $error("short sync width or level");
    a_sync_edge: assert property (@(posedge link_clk) disable iff (!presetn || !int_clk)
        $changed(port_frame_sync_o) |-> $changed(port_serial_clock_o)
        && port_serial_clock_o != fmt_q[5]) else $error("sync launched on wrong edge");
    a_data_edge: assert property (@(posedge link_clk) disable iff (!presetn || !int_clk)
        $changed(port_serial_data_out_o) |-> $changed(port_serial_clock_o)
        && port_serial_clock_o != fmt_q[5]) else $error("data launched on wrong edge");
endmodule // csf_codec_port_monitor

/* src/csf_byte_rev.sv */
// Reverses the low bytes of a sample; bytes above the sample width read as zero
`timescale 1ns/1ps
module csf_byte_rev (
    input wire logic en,
    input wire logic [2:0] nbytes,
    input wire logic [31:0] din,
    output logic [31:0] dout
);
    logic [31:0] rev;

    for (genvar i = 0; i < 4; i++) begin : g_byte
        always_comb begin
            rev[8*i+:8] = 8'h00;
            for (int j = 0; j < 4; j++) begin
                if ((i < nbytes) && (j == nbytes - 3'(i) - 3'h1)) begin
                    rev[8*i+:8] = din[8*j+:8];
                end
            end
        end
    end

    assign dout = en ? rev : din;
endmodule // csf_byte_rev

/* src/csf_codec_port.sv */
// Codec serial port: APB registers, format control and the serial link engine
`timescale 1ns/1ps
`include "csf_map.svh"
module csf_codec_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clk,
    input wire logic port_serial_clock_i,
    output logic port_serial_clock_o,
    output logic port_serial_clock_oe_n,
    input wire logic port_frame_sync_i,
    output logic port_frame_sync_o,
    output logic port_frame_sync_oe_n,
    output logic port_serial_data_out_o,
    output logic port_serial_data_out_oe_n,
    input wire logic port_serial_data_in_i
);
    import csf_pkg::*;

    // ****************************************
    // APB register file
    // ****************************************
    csf_pkg::csf_fmt_t fmt_q;
    csf_pkg::csf_ctrl_t ctrl_q;
    logic [31:0] tx_word_q;
    logic [31:0] rx_word_q;
    logic tx_tgl_q;
    logic tx_empty_q;
    logic rx_full_q;
    logic [15:0] idx;
    logic hit_fmt, hit_ctrl, hit_stat, hit_txd, hit_rxd, hit;
    logic acc, wr, rd;
    logic [2:0] nbytes;
    logic [31:0] tx_rev, rx_rev;
    logic tx_ack_s, tx_ack_seen_q, rx_tgl_s, rx_seen_q;
    logic [31:0] rx_hold_q;
    logic en_s;

    assign idx = paddr[17:2];
    assign hit_fmt = (idx == `CSF_IDX_FMT);
    assign hit_ctrl = (idx == `CSF_IDX_CTRL);
    assign hit_stat = (idx == `CSF_IDX_STAT);
    assign hit_txd = (idx == `CSF_IDX_TXD);
    assign hit_rxd = (idx == `CSF_IDX_RXD);
    assign hit = hit_fmt | hit_ctrl | hit_stat | hit_txd | hit_rxd;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;

    // Sample width in bytes follows the slot length
    assign nbytes = 3'((csf_slot_bits(ctrl_q.slot_length_code) + 6'h07) >> 3);

    csf_byte_rev u_tx_rev (
        .en(fmt_q.sample_byte_reverse),
        .nbytes(nbytes),
        .din(pwdata),
        .dout(tx_rev)
    );

    csf_byte_rev u_rx_rev (
        .en(fmt_q.sample_byte_reverse),
        .nbytes(nbytes),
        .din(rx_word_q),
        .dout(rx_rev)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_q <= `CSF_FMT_RST;
        end else if (wr && hit_fmt && !ctrl_q.port_enable_bit) begin
            fmt_q <= pwdata[7:0];
        end
    end

    // Enable stays writable so the port can be stopped; the rest freezes while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CSF_CTRL_RST;
        end else if (wr && hit_ctrl) begin
            if (!ctrl_q.port_enable_bit) begin
                ctrl_q <= pwdata[13:0];
            end else begin
                ctrl_q.port_enable_bit <= pwdata[0];
            end
        end
    end

    // Word stays put until the link acknowledges; software waits for empty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_word_q <= 32'h00000000;
            tx_tgl_q <= 1'b0;
        end else if (wr && hit_txd) begin
            tx_word_q <= tx_rev;
            tx_tgl_q <= ~tx_tgl_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ack_seen_q <= 1'b0;
            tx_empty_q <= 1'b1;
        end else begin
            tx_ack_seen_q <= tx_ack_s;
            if (tx_ack_s != tx_ack_seen_q) begin
                tx_empty_q <= 1'b1;
            end else if (wr && hit_txd) begin
                tx_empty_q <= 1'b0;
            end
        end
    end

    // Hold word is stable for a whole slot after its toggle, so it is copied safely
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_seen_q <= 1'b0;
            rx_word_q <= 32'h00000000;
            rx_full_q <= 1'b0;
        end else begin
            rx_seen_q <= rx_tgl_s;
            if (rx_tgl_s != rx_seen_q) begin
                rx_word_q <= rx_hold_q;
                rx_full_q <= 1'b1;
            end else if (rd && hit_rxd) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h00000000;
            if (hit_fmt) begin
                prdata[7:0] <= fmt_q;
            end
            if (hit_ctrl) begin
                prdata[13:0] <= ctrl_q;
            end
            if (hit_stat) begin
                prdata[`CSF_STAT_TXE] <= tx_empty_q;
                prdata[`CSF_STAT_RXF] <= rx_full_q;
                prdata[`CSF_STAT_EN] <= en_s;
            end
            if (hit_rxd) begin
                prdata <= rx_rev;
            end
        end
    end

    // ****************************************
    // Link domain reset and crossings
    // ****************************************
    logic lrst1_q, lrst_n;
    logic en_l, tx_tgl_l, tx_seen_l_q, tx_ack_q, rx_tgl_q;
    logic sck_s, fs_s, sdi_s;

    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            lrst1_q <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst1_q <= 1'b1;
            lrst_n <= lrst1_q;
        end
    end

    // Format and slot fields are static while enabled, so only enable crosses
    csf_sync3 u_en (.clk(link_clk), .rst_n(lrst_n), .d(ctrl_q.port_enable_bit), .q(en_l));
    csf_sync3 u_txt (.clk(link_clk), .rst_n(lrst_n), .d(tx_tgl_q), .q(tx_tgl_l));
    csf_sync3 u_ack (.clk(pclk), .rst_n(presetn), .d(tx_ack_q), .q(tx_ack_s));
    csf_sync3 u_rxt (.clk(pclk), .rst_n(presetn), .d(rx_tgl_q), .q(rx_tgl_s));
    csf_sync3 u_ens (.clk(pclk), .rst_n(presetn), .d(en_l), .q(en_s));
    csf_sync3 u_sck (.clk(link_clk), .rst_n(lrst_n), .d(port_serial_clock_i), .q(sck_s));
    csf_sync3 u_fs (.clk(link_clk), .rst_n(lrst_n), .d(port_frame_sync_i), .q(fs_s));
    csf_sync3 u_sdi (.clk(link_clk), .rst_n(lrst_n), .d(port_serial_data_in_i), .q(sdi_s));

    // ****************************************
    // Link timing
    // ****************************************
    logic ext_clk, ext_fs, pol;
    logic [1:0] div_q;
    logic sck_gen_q, sck_prev_q;
    logic rise, fall, launch, sample;
    logic [3:0] samp_pipe_q;
    logic samp_now;
    logic [5:0] slot_len, s0len, act_len, sync_len;
    logic [9:0] frame_len, act_start, gen_q, gen_d, pos_d, pos_q, samp_pos_q;
    logic resync_q, fs_prev_q, fs_act;
    csf_pkg::csf_link_t state_q;

    assign ext_clk = fmt_q.serial_clock_direction;
    assign ext_fs = fmt_q.frame_sync_direction;
    assign pol = fmt_q.serial_clock_edge_polarity;

    always_comb begin
        slot_len = csf_slot_bits(ctrl_q.slot_length_code);
        case (csf_s0len_t'(ctrl_q.slot_zero_length))
            CSF_S0_8: s0len = 6'h08;
            CSF_S0_16: s0len = 6'h10;
            CSF_S0_32: s0len = 6'h20;
            default: s0len = slot_len;
        endcase
        frame_len = 10'(s0len) + 10'(ctrl_q.slots_minus_one) * 10'(slot_len);
        act_len = (ctrl_q.active_slot == 4'h0) ? s0len : slot_len;
        act_start = (ctrl_q.active_slot == 4'h0) ? 10'h000 :
            10'(s0len) + 10'(ctrl_q.active_slot - 4'h1) * 10'(slot_len);
        sync_len = fmt_q.frame_sync_length_bit ? s0len : 6'h01;
    end

    // Internal clock runs at a quarter of the link clock
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            div_q <= 2'h0;
            sck_gen_q <= 1'b0;
        end else if (!en_l || ext_clk) begin
            div_q <= 2'h0;
            sck_gen_q <= 1'b0;
        end else if (div_q == `CSF_SCLK_HALF - 2'h1) begin
            div_q <= 2'h0;
            sck_gen_q <= ~sck_gen_q;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
        end
    end

    always_comb begin
        if (ext_clk) begin
            rise = en_l & sck_s & ~sck_prev_q;
            fall = en_l & ~sck_s & sck_prev_q;
        end else begin
            rise = en_l & ~ext_clk & (div_q == `CSF_SCLK_HALF - 2'h1) & ~sck_gen_q;
            fall = en_l & (div_q == `CSF_SCLK_HALF - 2'h1) & sck_gen_q;
        end
        launch = pol ? fall : rise;
        sample = pol ? rise : fall;
    end

    // Own clock edges lead the synchronised data pin, so the sample waits it out
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            samp_pipe_q <= 4'h0;
            samp_pos_q <= 10'h000;
        end else begin
            samp_pipe_q <= {samp_pipe_q[2:0], sample};
            samp_pos_q <= (sample || ext_clk) ? pos_q : samp_pos_q;
        end
    end
    assign samp_now = ext_clk ? sample : samp_pipe_q[`CSF_SAMP_LAG - 1];

    assign fs_act = en_l & (fs_s ~^ fmt_q.frame_sync_polarity);

    // External sync leading edge realigns the frame counter
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            fs_prev_q <= 1'b0;
            resync_q <= 1'b0;
        end else begin
            if (sample) begin
                fs_prev_q <= fs_act;
            end
            if (!en_l || !ext_fs || launch) begin
                resync_q <= 1'b0;
            end
            if (ext_fs && sample && fs_act && !fs_prev_q) begin
                resync_q <= 1'b1;
            end
        end
    end

    always_comb begin
        if (ext_fs) begin
            gen_d = resync_q ? 10'h001 : ((gen_q == frame_len - 10'h1) ? 10'h000 : gen_q + 10'h1);
        end else begin
            gen_d = ((state_q == CSF_LINK_IDLE) || (gen_q == frame_len - 10'h1)) ?
                10'h000 : gen_q + 10'h1;
        end
        if (fmt_q.data_delay_bit) begin
            pos_d = (gen_d == 10'h000) ? frame_len - 10'h1 : gen_d - 10'h1;
        end else begin
            pos_d = gen_d;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            state_q <= CSF_LINK_IDLE;
            gen_q <= 10'h000;
            pos_q <= 10'h000;
        end else if (!en_l) begin
            state_q <= CSF_LINK_IDLE;
            gen_q <= 10'h000;
            pos_q <= 10'h000;
        end else if (launch && (!ext_fs || resync_q || state_q == CSF_LINK_RUN)) begin
            state_q <= CSF_LINK_RUN;
            gen_q <= gen_d;
            pos_q <= pos_d;
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    logic in_act_d, in_act_q;
    logic [9:0] bit_d, bit_q;
    logic [31:0] tx_cur_q;
    logic [31:0] rx_sh_q;

    assign bit_d = pos_d - act_start;
    assign in_act_d = (pos_d >= act_start) && (bit_d < 10'(act_len));
    assign bit_q = samp_pos_q - act_start;
    assign in_act_q = (state_q == CSF_LINK_RUN) && (samp_pos_q >= act_start) &&
        (bit_q < 10'(act_len));

    assign port_serial_clock_o = sck_gen_q;
    assign port_serial_clock_oe_n = ~en_l | ext_clk;

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            port_frame_sync_o <= 1'b0;
            port_frame_sync_oe_n <= 1'b1;
        end else begin
            port_frame_sync_oe_n <= ~en_l | ext_fs;
            if (!en_l) begin
                port_frame_sync_o <= ~fmt_q.frame_sync_polarity;
            end else if (launch) begin
                port_frame_sync_o <= (gen_d < 10'(sync_len)) ~^ fmt_q.frame_sync_polarity;
            end
        end
    end

    // A new word is taken at the start of the active slot, else the last one repeats
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            tx_cur_q <= 32'h00000000;
            tx_seen_l_q <= 1'b0;
            tx_ack_q <= 1'b0;
        end else if (launch && in_act_d && bit_d == 10'h000 && tx_tgl_l != tx_seen_l_q) begin
            tx_cur_q <= tx_word_q;
            tx_seen_l_q <= tx_tgl_l;
            tx_ack_q <= ~tx_ack_q;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            port_serial_data_out_o <= 1'b0;
            port_serial_data_out_oe_n <= 1'b1;
        end else if (!en_l) begin
            port_serial_data_out_o <= 1'b0;
            port_serial_data_out_oe_n <= 1'b1;
        end else if (launch) begin
            port_serial_data_out_o <= 1'b0;
            port_serial_data_out_oe_n <= ~in_act_d & fmt_q.unused_slot_hiz_bit;
            if (in_act_d) begin
                if (bit_d == 10'h000 && tx_tgl_l != tx_seen_l_q) begin
                    port_serial_data_out_o <= tx_word_q[5'(act_len - 6'h1)];
                end else begin
                    port_serial_data_out_o <= tx_cur_q[5'(10'(act_len) - 10'h1 - bit_d)];
                end
            end
        end
    end

    // Samples arrive msb first and land right-justified
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            rx_sh_q <= 32'h00000000;
            rx_hold_q <= 32'h00000000;
            rx_tgl_q <= 1'b0;
        end else if (samp_now && in_act_q) begin
            if (bit_q == 10'h000) begin
                rx_sh_q <= {31'h00000000, sdi_s};
            end else begin
                rx_sh_q <= {rx_sh_q[30:0], sdi_s};
            end
            if (bit_q == 10'(act_len) - 10'h1) begin
                rx_hold_q <= {rx_sh_q[30:0], sdi_s};
                rx_tgl_q <= ~rx_tgl_q;
            end
        end
    end
endmodule // csf_codec_port

/* src/csf_map.svh */
// Register map, field positions, reset values and timing counts of the codec format block
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define CSF_IDX_FMT 16'hffde
`define CSF_IDX_CTRL 16'hffe8
`define CSF_IDX_STAT 16'hffe9
`define CSF_IDX_TXD 16'hffea
`define CSF_IDX_RXD 16'hffeb

// ****************************************
// Reset values and field positions
// ****************************************
`define CSF_FMT_RST 8'h30
`define CSF_CTRL_RST 14'h0000
`define CSF_STAT_TXE 0
`define CSF_STAT_RXF 1
`define CSF_STAT_EN 2

// ****************************************
// Timing counts (link clock cycles)
// ****************************************
`define CSF_SCLK_HALF 2'h2
`define CSF_SAMP_LAG 3

`endif

/* src/csf_pkg.sv */
// Types shared by the codec format block
package csf_pkg;
    // Format register, bit 7 down to bit 0
    typedef struct packed {
        logic data_delay_bit;
        logic unused_slot_hiz_bit;
        logic serial_clock_edge_polarity;
        logic frame_sync_polarity;
        logic frame_sync_length_bit;
        logic sample_byte_reverse;
        logic serial_clock_direction;
        logic frame_sync_direction;
    } csf_fmt_t;

    // Port control register, bit 13 down to bit 0
    typedef struct packed {
        logic [3:0] active_slot;
        logic [3:0] slots_minus_one;
        logic [2:0] slot_length_code;
        logic [1:0] slot_zero_length;
        logic port_enable_bit;
    } csf_ctrl_t;

    typedef enum logic [1:0] {
        CSF_S0_SAME = 2'b00,
        CSF_S0_8 = 2'b01,
        CSF_S0_16 = 2'b10,
        CSF_S0_32 = 2'b11
    } csf_s0len_t;

    typedef enum logic {
        CSF_LINK_IDLE = 1'b0,
        CSF_LINK_RUN = 1'b1
    } csf_link_t;

    function automatic logic [5:0] csf_slot_bits(input logic [2:0] code);
        case (code)
            3'h0: csf_slot_bits = 6'h08;
            3'h1: csf_slot_bits = 6'h10;
            3'h2: csf_slot_bits = 6'h12;
            3'h3: csf_slot_bits = 6'h14;
            3'h4: csf_slot_bits = 6'h18;
            default: csf_slot_bits = 6'h20;
        endcase
    endfunction
endpackage

/* src/csf_sync3.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module csf_sync3 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            q <= 1'b0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q <= s3_q;
            end
        end
    end
endmodule // csf_sync3
